// ---- rtl/flash_status_poller.sv ----
/*
  host-side polling controller for a parallel flash in program or erase.
  software starts a check over a small local register port; the
  controller then runs the toggle-bit procedure on the flash pins.
  assumes the ready/busy pin is pulled up externally.
*/
`timescale 1ns/1ns
module flash_status_poller
  import flash_poll_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [19:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  input wire logic [7:0] flash_dq_in,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic ready_busy_out
);
  typedef enum logic [6:0] {
    st_idle = 7'b0000001,
    st_rd1 = 7'b0000010,
    st_rd2 = 7'b0000100,
    st_rd3 = 7'b0001000,
    st_rst = 7'b0010000,
    st_win = 7'b0100000,
    st_fin = 7'b1000000
  } poll_state_e;

  poll_state_e state_r;
  poll_state_e state_nxt;
  logic [19:0] addr_r;
  logic [7:0] first_r;
  logic [7:0] second_r;
  logic busy_r;
  logic done_r;
  logic fail_r;
  logic window_r;
  logic rejected_r;
  logic window_chk_r;
  logic [7:0] last_r;
  logic rb_s1_r;
  logic rb_s2_r;
  logic cyc_start;
  logic cyc_go;
  logic pend_r;
  logic cyc_write;
  logic cyc_done;
  logic [7:0] cyc_rdata;
  logic go;

  assign go = reg_wr && (reg_addr_in == reg_ctrl) && reg_wdata[ctrl_start_bit];

  // ==========================================================
  // one bus cycle per state visit; the request stays high while the
  // state waits, so without this a second cycle would start on done
  assign cyc_go = cyc_start && !pend_r;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pend_r <= 1'b0;
    end else if (cyc_done) begin
      pend_r <= 1'b0;
    end else if (cyc_go) begin
      pend_r <= 1'b1;
    end
  end

  // ==========================================================
  // ready/busy pin synchroniser
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rb_s1_r <= 1'b0;
      rb_s2_r <= 1'b0;
    end else begin
      rb_s1_r <= ready_busy_out;
      rb_s2_r <= rb_s1_r;
    end
  end

  // ==========================================================
  // bus cycle engine
  flash_bus_cycle u_cycle (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(cyc_go),
    .write(cyc_write),
    .addr(addr_r),
    .wdata(flash_reset_cmd),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .flash_addr(flash_addr),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n),
    .flash_dq_in(flash_dq_in),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe)
  );

  // ==========================================================
  // polling sequence state
  always_comb begin
    state_nxt = state_r;
    cyc_start = 1'b0;
    cyc_write = 1'b0;
    case (state_r)
      st_idle: begin
        if (go) begin
          state_nxt = st_rd1;
        end
      end
      st_rd1: begin
        cyc_start = 1'b1;
        if (cyc_done) begin
          state_nxt = st_rd2;
        end
      end
      st_rd2: begin
        cyc_start = 1'b1;
        if (cyc_done) begin
          if (cyc_rdata[primary_toggle_bit] == first_r[primary_toggle_bit]) begin
            state_nxt = window_chk_r ? st_win : st_fin;
          end else if (cyc_rdata[timeout_fail_bit]) begin
            state_nxt = st_rd3;
          end else begin
            state_nxt = st_rd1;
          end
        end
      end
      st_rd3: begin
        cyc_start = 1'b1;
        if (cyc_done) begin
          if (cyc_rdata[primary_toggle_bit] == second_r[primary_toggle_bit]) begin
            state_nxt = st_fin;
          end else begin
            state_nxt = st_rst;
          end
        end
      end
      st_rst: begin
        cyc_start = 1'b1;
        cyc_write = 1'b1;
        if (cyc_done) begin
          state_nxt = st_fin;
        end
      end
      st_win: begin
        cyc_start = 1'b1;
        if (cyc_done) begin
          state_nxt = st_fin;
        end
      end
      st_fin: state_nxt = st_idle;
      default: state_nxt = st_idle;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= st_idle;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // captured reads and address
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      first_r <= 8'h00;
      second_r <= 8'h00;
      last_r <= 8'h00;
      addr_r <= 20'h00000;
      window_chk_r <= 1'b0;
    end else begin
      if (reg_wr && reg_addr_in == reg_addr) begin
        addr_r <= reg_wdata[19:0];
      end
      // a start while busy is ignored, its options too
      if (go && state_r == st_idle) begin
        window_chk_r <= reg_wdata[ctrl_window_bit];
      end
      if (cyc_done && !cyc_write) begin
        last_r <= cyc_rdata;
        if (state_r == st_rd1) begin
          first_r <= cyc_rdata;
        end
        if (state_r == st_rd2) begin
          second_r <= cyc_rdata;
        end
      end
    end
  end

  // ==========================================================
  // result flags; a new start clears done, fail and rejected, sets busy and loads window
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      fail_r <= 1'b0;
      window_r <= 1'b0;
      rejected_r <= 1'b0;
    end else begin
      if (go && state_r == st_idle) begin
        busy_r <= 1'b1;
        done_r <= 1'b0;
        fail_r <= 1'b0;
        rejected_r <= 1'b0;
        // window state before the extra command
        window_r <= last_r[erase_window_bit];
      end
      if (state_r == st_rst && cyc_done) begin
        fail_r <= 1'b1;
      end
      if (state_r == st_win && cyc_done) begin
        // high on second check means maybe rejected
        rejected_r <= cyc_rdata[erase_window_bit];
        window_r <= cyc_rdata[erase_window_bit];
      end
      if (state_r == st_fin) begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // register read port, data one cycle after strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= zero_word;
    end else begin
      reg_rdata <= zero_word;
      if (reg_rd) begin
        case (reg_addr_in)
          reg_status: begin
            reg_rdata[st_busy_bit] <= busy_r;
            reg_rdata[st_done_bit] <= done_r;
            reg_rdata[st_fail_bit] <= fail_r;
            reg_rdata[st_window_bit] <= window_r;
            reg_rdata[st_ready_bit] <= rb_s2_r;
            reg_rdata[st_rejected_bit] <= rejected_r;
          end
          reg_addr: reg_rdata[19:0] <= addr_r;
          reg_data: reg_rdata[7:0] <= last_r;
          default: reg_rdata <= zero_word;
        endcase
      end
    end
  end
endmodule

// ---- include/flash_poll_pkg.sv ----
/*
  constants for the flash status polling controller.
  assumes a 50 MHz system clock and an 8-bit parallel flash data bus.
*/
// Contract
// - programming non-blank cell locks device; host must send reset sequence.
// - host checks window bit before and after each extra sector erase.
// - host reads status twice, compares toggle bits; equal means done.
// - toggling with timeout high: recheck; still toggling means fail, reset.
// - host returning from other work restarts check from first read.
package flash_poll_pkg;
  // ==========================================================
  // register map of the controller (word index on local port)
  localparam logic [3:0] reg_ctrl = 4'h0;
  localparam logic [3:0] reg_status = 4'h1;
  localparam logic [3:0] reg_addr = 4'h2;
  localparam logic [3:0] reg_data = 4'h3;
  // ctrl fields
  localparam int ctrl_start_bit = 0;
  localparam int ctrl_erase_bit = 1;
  localparam int ctrl_window_bit = 2;
  // status fields
  localparam int st_busy_bit = 0;
  localparam int st_done_bit = 1;
  localparam int st_fail_bit = 2;
  localparam int st_window_bit = 3;
  localparam int st_ready_bit = 4;
  localparam int st_rejected_bit = 5;
  // flash status bit positions
  localparam int polling_status_bit = 7;
  localparam int primary_toggle_bit = 6;
  localparam int timeout_fail_bit = 5;
  localparam int erase_window_bit = 3;
  localparam int second_toggle_bit = 2;
  // ==========================================================
  // bus timing
  localparam int clk_period_ns = 20;
  localparam int read_time_ns = 100;
  localparam int read_cycles =
    (read_time_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int gap_time_ns = 40;
  localparam int gap_cycles = (gap_time_ns + clk_period_ns - 1) / clk_period_ns;
  localparam logic [7:0] flash_reset_cmd = 8'hf0;
  localparam logic [31:0] zero_word = 32'h0000_0000;
endpackage

// ---- rtl/flash_bus_cycle.sv ----
/*
  one flash bus cycle: read or write with chip select and strobes.
  assumes the flash data pins are sampled through a two-stage synchroniser.
*/
`timescale 1ns/1ns
module flash_bus_cycle
  import flash_poll_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start,
  input wire logic write,
  input wire logic [19:0] addr,
  input wire logic [7:0] wdata,
  output logic done,
  output logic [7:0] rdata,
  output logic [19:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  input wire logic [7:0] flash_dq_in,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe
);
  logic [7:0] cnt_r;
  logic act_r;
  logic wr_r;
  logic [7:0] dq_s1_r;
  logic [7:0] dq_s2_r;

  // ==========================================================
  // data pin synchroniser
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dq_s1_r <= 8'h00;
      dq_s2_r <= 8'h00;
    end else begin
      dq_s1_r <= flash_dq_in;
      dq_s2_r <= dq_s1_r;
    end
  end

  // ==========================================================
  // strobe sequencer; extra gap covers the synchroniser delay
  // every read toggles oe so the device advances its toggle bits
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      act_r <= 1'b0;
      wr_r <= 1'b0;
      cnt_r <= 8'h00;
      done <= 1'b0;
      rdata <= 8'h00;
      flash_addr <= 20'h00000;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_dq_out <= 8'h00;
      flash_dq_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!act_r && start) begin
        act_r <= 1'b1;
        wr_r <= write;
        cnt_r <= 8'h00;
        flash_addr <= addr;
        flash_dq_out <= wdata;
        flash_dq_oe <= write;
        flash_ce_n <= 1'b0;
        flash_oe_n <= write;
        flash_we_n <= !write;
      end else if (act_r) begin
        cnt_r <= cnt_r + 8'h01;
        if (cnt_r == 8'(read_cycles - 1)) begin
          flash_ce_n <= 1'b1;
          flash_oe_n <= 1'b1;
          flash_we_n <= 1'b1;
        end
        // the sample from the last edge with the strobe low leaves the
        // synchroniser here; later the released bus no longer holds it
        if (!wr_r && cnt_r == 8'(read_cycles + 1)) begin
          rdata <= dq_s2_r;
        end
        if (cnt_r == 8'(read_cycles + gap_cycles)) begin
          act_r <= 1'b0;
          done <= 1'b1;
          flash_dq_oe <= 1'b0;
        end
      end
    end
  end
endmodule

// ---- dv/flash_status_poller_assertions.sv ----
/*
  port checker for the flash status poller.
  assumes one clock domain; bound to the top module below.
*/
`timescale 1ns/1ns
module flash_status_poller_assertions
  import flash_poll_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reg_rd,
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_rdata,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic [7:0] flash_dq_out,
  input wire logic flash_dq_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ==========================================================
  // strobe shape: five cycles low, then released
  sequence s_low5(s);
    !s[*5] ##1 s;
  endsequence
  property p_rd_len; $fell(flash_oe_n) |-> s_low5(flash_oe_n); endproperty
  a_rd_len: assert property (p_rd_len) else $error("read strobe length");
  property p_gap; $rose(flash_oe_n) |=> flash_oe_n; endproperty
  a_gap: assert property (p_gap) else $error("reads not separated");
  property p_oe_ce; !flash_oe_n |-> !flash_ce_n; endproperty
  a_oe_ce: assert property (p_oe_ce) else $error("read without select");
  // bus fight: never drive data while the flash drives it
  property p_drive; flash_dq_oe |-> flash_oe_n; endproperty
  a_drive: assert property (p_drive) else $error("data driven in read");
  property p_we_len; $fell(flash_we_n) |-> s_low5(flash_we_n); endproperty
  a_we_len: assert property (p_we_len) else $error("write strobe length");
  // the only write this block ever makes is the reset command
  property p_cmd; !flash_we_n |-> flash_dq_oe && flash_dq_out == flash_reset_cmd; endproperty
  a_cmd: assert property (p_cmd) else $error("bad command write");
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_unmap; reg_rd && reg_addr_in > 4'h3 |=> reg_rdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule

bind flash_status_poller flash_status_poller_assertions u_chk (
  .clk_sys(clk_sys), .rst(rst), .reg_rd(reg_rd), .reg_addr_in(reg_addr_in),
  .reg_rdata(reg_rdata), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
  .flash_we_n(flash_we_n), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe)
);

// ---- dv/flash_model.sv ----
/*
  behavioural flash status model, busy for a set number of reads, or until a reset command when locked.
  assumes the bench arms it with a load pulse before each check started through go.
*/
`timescale 1ns/1ns
module flash_model
  import flash_poll_pkg::*;
(
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic [7:0] flash_dq_out,
  input wire logic load,
  input wire logic [7:0] n_busy,
  input wire logic tmo,
  input wire logic lock,
  output logic [7:0] flash_dq_in,
  output logic ready_busy_out,
  output logic got_reset
);
  logic [7:0] left_r = 8'h00;
  logic [7:0] last_r = 8'h00;
  logic tog_r = 1'b0;
  logic tmo_r = 1'b0;
  logic lock_r = 1'b0;
  logic busy;
  logic [7:0] val;
  initial got_reset = 1'b0;
  // pin pulled low only while busy
  assign busy = lock_r || left_r != 8'h00;
  assign ready_busy_out = !busy;
  // erase status byte: polling 0, window closed, erase running
  // locked program byte: second toggle reads 1, only the primary toggles
  assign val = !busy ? 8'h5a :
    lock_r ? {1'b1, tog_r, tmo_r, 3'b001, 2'b00} : {1'b0, tog_r, tmo_r, 2'b01, tog_r, 2'b00};
  // released bus shows the inverse, so a late sample never matches
  assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? val : ~last_r;
  // arming stands for the last command edge; busy a set count, or until reset when locked, data kept
  always @(posedge load) begin
    left_r = n_busy;
    tmo_r = tmo;
    lock_r = lock;
    tog_r = 1'b0;
    got_reset = 1'b0;
  end
  // each read while busy ends with a toggle; reads never end a lock
  always @(posedge flash_oe_n) begin
    last_r = val;
    if (busy) tog_r = !tog_r;
    if (left_r != 8'h00 && !lock_r) left_r = left_r - 8'h01;
  end
  // reset command leaves the failed state
  always @(posedge flash_we_n) begin
    if (flash_dq_out == flash_reset_cmd) begin
      lock_r = 1'b0;
      left_r = 8'h00;
      got_reset = 1'b1;
    end
  end
endmodule

// ---- dv/flash_status_poller_tb.sv ----
/*
  self-checking bench for the flash status poller.
  assumes the flash model in dv and the register map of the package.
*/
`timescale 1ns/1ns
module flash_status_poller_tb
  import flash_poll_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr_in = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic load = 1'b0;
  logic [7:0] n_busy = 8'h00;
  logic tmo = 1'b0;
  logic lock = 1'b0;
  logic [31:0] reg_rdata, st;
  logic [19:0] flash_addr;
  logic flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe, ready_busy_out, got_reset;
  logic [7:0] flash_dq_in, flash_dq_out;
  int fail_count = 0;
  int n_tests = 0;
  always #10 clk_sys = ~clk_sys;
  flash_status_poller u_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr_in(reg_addr_in),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flash_addr(flash_addr), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n), .flash_dq_in(flash_dq_in), .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe), .ready_busy_out(ready_busy_out));
  flash_model u_flash (.flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n), .flash_dq_out(flash_dq_out), .load(load), .n_busy(n_busy),
    .tmo(tmo), .lock(lock), .flash_dq_in(flash_dq_in), .ready_busy_out(ready_busy_out),
    .got_reset(got_reset));
  // ==========================================================
  // register port tasks; each starts just after a rising edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr_in <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    // one edge passes so a following call never drives the strobe twice at once
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    reg_addr_in <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk_sys);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // arm the model, then start a check at a fixed address
  task automatic go(input logic [7:0] n, input logic t, input logic l);
    n_busy <= n;
    tmo <= t;
    lock <= l;
    load <= 1'b1;
    @(posedge clk_sys);
    load <= 1'b0;
    repeat (4) @(posedge clk_sys);
    wr(reg_addr, 32'h0001_2345);
    wr(reg_ctrl, 32'h1);
  endtask
  // bounded poll of the status register
  task automatic wait_end();
    for (int i = 0; i < 100; i++) begin
      rd(reg_status, st);
      if (st[st_done_bit] === 1'b1 || st[st_fail_bit] === 1'b1) return;
    end
    fail_count++;
    conclude();
  endtask
  // ==========================================================
  // scenarios
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rd(reg_status, st);
    chk(st, 32'h10);
    rd(4'hf, st);
    chk(st, 32'h0);
    go(8'h00, 1'b0, 1'b0);
    wait_end();
    chk(st & 32'h7, 32'h2);
    rd(reg_data, st);
    chk(st & 32'hff, 32'h5a);
    chk({12'h000, flash_addr}, 32'h0001_2345);
    rd(reg_addr, st);
    chk(st, 32'h0001_2345);
    // busy for three reads: polling repeats until two reads agree
    go(8'h03, 1'b0, 1'b0);
    rd(reg_status, st);
    chk(st & 32'h11, 32'h01);
    wait_end();
    chk(st & 32'h7, 32'h2);
    chk({31'h0, got_reset}, 32'h0);
    // timeout bit high while toggling; toggling has stopped by the recheck
    go(8'h02, 1'b1, 1'b0);
    wait_end();
    chk(st & 32'h7, 32'h2);
    // locked device: fail and the reset command
    go(8'h00, 1'b1, 1'b1);
    wait_end();
    chk(st & 32'h4, 32'h4);
    chk({31'h0, got_reset}, 32'h1);
    // window check after an extra sector erase: bit seen high, maybe rejected
    wr(reg_ctrl, 32'h5);
    wait_end();
    chk(st & 32'h3f, 32'h3a);
    conclude();
  end
endmodule
